//--- design/tasf_cfg.svh
// Register offsets, field positions and reset values of the three-axis sample buffer.
// Included by the buffer module only; holds definitions only.
`ifndef TASF_CFG_SVH
`define TASF_CFG_SVH

// Register addresses (7-bit register index)
`define TASF_ADDR_ROUTE      7'h22
`define TASF_ADDR_X_LOW      7'h28
`define TASF_ADDR_X_HIGH     7'h29
`define TASF_ADDR_Y_LOW      7'h2A
`define TASF_ADDR_Y_HIGH     7'h2B
`define TASF_ADDR_Z_LOW      7'h2C
`define TASF_ADDR_Z_HIGH     7'h2D
`define TASF_ADDR_CTRL       7'h2E
`define TASF_ADDR_SRC        7'h2F
`define TASF_ADDR_TRIG_CFG   7'h30

// Buffer control fields
`define TASF_CTRL_MODE_MSB   7
`define TASF_CTRL_MODE_LSB   5
`define TASF_CTRL_THR_MSB    4
`define TASF_CTRL_THR_LSB    0

// Interrupt routing control fields
`define TASF_ROUTE_WTM_BIT   2
`define TASF_ROUTE_FULL_BIT  1
`define TASF_ROUTE_EMPTY_BIT 0

// Trigger configuration: low six bits select interrupt-1 events
`define TASF_TRIG_MSB        5

// Reset values
`define TASF_RST_CTRL        8'h00
`define TASF_RST_ROUTE       8'h00
`define TASF_RST_TRIG_CFG    8'h00

// Depth and fill figures
`define TASF_DEPTH           32
`define TASF_FULL_COUNT      6'h20

`endif

//--- design/tasf_pkg.sv
// Types of the three-axis sample buffer: buffer modes and the behaviour in force.
// Does not include tasf_cfg.svh; the mode codes are written out here.
package tasf_pkg;

	typedef enum logic [2:0] {
		TASF_MODE_BYPASS    = 3'b000,
		TASF_MODE_FIFO      = 3'b001,
		TASF_MODE_STREAM    = 3'b010,
		TASF_MODE_STR2FIFO  = 3'b011,
		TASF_MODE_BYP2STR   = 3'b100
	} tasf_mode_t;

	typedef enum logic [1:0] {
		TASF_EFF_BYPASS = 2'b00,
		TASF_EFF_FIFO   = 2'b01,
		TASF_EFF_STREAM = 2'b10
	} tasf_eff_t;

endpackage

//--- design/tasf_buffer.sv
// Three-axis sample buffer with mode control, event source and second interrupt pin.
// Assumes the serial register front end gives one-cycle read and write strobes on sys_clk_i,
// and that samples and interrupt-1 events come from logic on the same clock.
//
// Summary of operation
// R01: Thirty-two sixteen-bit entries are kept for each of the three axes.
// R02: Five buffer modes are selected by the mode field of buffer control.
// R03: Threshold, empty and full events route to pin two; source register reports them.
// R04: A five-bit fill threshold is held and compared against the fill level.
// R05: Bypass keeps only entry zero, overwritten each sample; the buffer stays empty.
// R06: Fifo mode stores all axes and flags reaching the threshold when enabled.
// R07: Fifo mode stops storing when full; writing bypass restarts collection.
// R08: Stream mode keeps storing; when full the oldest sample is dropped.
// R09: Stream mode threshold interrupt is enabled and programmed as in fifo mode.
// R10: Bypass-to-stream acts as bypass until an interrupt-1 trigger, then as stream.
// R11: Stream-to-fifo acts as stream until an interrupt-1 trigger, then as fifo.
// R12: Stream-to-fifo threshold event reaches pin two through the routing control bit.
// R13: Outside bypass, axis output reads return buffered samples, not the live value.
// R14: Each retrieval shows the oldest stored sample; single and burst reads work.
// R15: After reading the third-axis high byte the burst address wraps to first-axis low.
// R16: Reading the third-axis high byte consumes a sample; zero unread sets empty.
// R17: Full is set when all entries hold unread samples, cleared on consumption.
`timescale 1ns/1ps
`default_nettype none
`include "tasf_cfg.svh"

module tasf_buffer
	import tasf_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        sample_valid_i,
	input  wire logic [15:0] sample_x_i,
	input  wire logic [15:0] sample_y_i,
	input  wire logic [15:0] sample_z_i,
	input  wire logic [5:0]  int1_events_i,
	input  wire logic [6:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_rd_i,
	output var  logic [7:0]  reg_rdata_o,
	output var  logic [6:0]  reg_next_addr_o,
	output var  logic        second_irq_pin_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0]  buffer_control_reg;
	logic [7:0]  interrupt_routing_control_reg;
	logic [7:0]  trigger_event_config_reg;
	logic [47:0] mem_reg [`TASF_DEPTH];
	logic [4:0]  wr_ptr_reg;
	logic [4:0]  rd_ptr_reg;
	logic [5:0]  count_reg;
	logic        triggered_reg;
	logic [7:0]  rdata_reg;
	logic [6:0]  next_addr_reg;
	logic        irq_reg;

	tasf_mode_t  mode;
	tasf_eff_t   eff;
	logic [4:0]  fill_threshold;
	logic        ctrl_wr;
	logic        trig_hit;
	logic        buf_full;
	logic        buf_empty;
	logic        wtm_hit;
	logic        push;
	logic        pop;
	logic        drop;
	logic        slot_wr;
	logic [4:0]  slot_idx;
	logic [47:0] head;
	logic [7:0]  src_byte;
	logic [7:0]  rd_mux;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode and flags

	assign mode           = tasf_mode_t'(buffer_control_reg[`TASF_CTRL_MODE_MSB:`TASF_CTRL_MODE_LSB]);
	assign fill_threshold = buffer_control_reg[`TASF_CTRL_THR_MSB:`TASF_CTRL_THR_LSB]; // R04
	assign ctrl_wr        = reg_wr_i && (reg_addr_i == `TASF_ADDR_CTRL);
	assign trig_hit       = |(int1_events_i & trigger_event_config_reg[`TASF_TRIG_MSB:0]);

	always_comb begin
		unique case (mode) // R02
			TASF_MODE_BYPASS:   eff = TASF_EFF_BYPASS;
			TASF_MODE_FIFO:     eff = TASF_EFF_FIFO;
			TASF_MODE_STREAM:   eff = TASF_EFF_STREAM;
			TASF_MODE_STR2FIFO: eff = triggered_reg ? TASF_EFF_FIFO : TASF_EFF_STREAM; // R11
			TASF_MODE_BYP2STR:  eff = triggered_reg ? TASF_EFF_STREAM : TASF_EFF_BYPASS; // R10
			// Unassigned mode codes fall back to bypass so only slot zero is written and nothing is buffered
			default:            eff = TASF_EFF_BYPASS;
		endcase
	end

	assign buf_full  = (count_reg == `TASF_FULL_COUNT); // R17
	assign buf_empty = (count_reg == 6'h00); // R16
	assign wtm_hit   = (count_reg >= {1'b0, fill_threshold}); // R04

	// Fifo refuses samples once full; stream always accepts
	assign push    = sample_valid_i && (eff != TASF_EFF_BYPASS)
		&& !((eff == TASF_EFF_FIFO) && buf_full); // R07
	assign pop     = reg_rd_i && (reg_addr_i == `TASF_ADDR_Z_HIGH)
		&& (eff != TASF_EFF_BYPASS) && !buf_empty; // R16
	assign drop    = push && buf_full && !pop; // R08
	assign slot_wr = push || (sample_valid_i && (eff == TASF_EFF_BYPASS)); // R05
	assign slot_idx = (eff == TASF_EFF_BYPASS) ? 5'h00 : wr_ptr_reg; // R05
	assign head    = mem_reg[rd_ptr_reg]; // R14

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			buffer_control_reg <= `TASF_RST_CTRL;
		end else if (ctrl_wr) begin
			buffer_control_reg <= reg_wdata_i; // R02
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			interrupt_routing_control_reg <= `TASF_RST_ROUTE;
		end else if (reg_wr_i && (reg_addr_i == `TASF_ADDR_ROUTE)) begin
			interrupt_routing_control_reg <= reg_wdata_i; // R03
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			trigger_event_config_reg <= `TASF_RST_TRIG_CFG;
		end else if (reg_wr_i && (reg_addr_i == `TASF_ADDR_TRIG_CFG)) begin
			trigger_event_config_reg <= reg_wdata_i;
		end
	end

	// Trigger latch; any control write re-arms it, so rewriting the mode starts over
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			triggered_reg <= 1'b0;
		end else if (ctrl_wr) begin
			triggered_reg <= 1'b0;
		end else if (trig_hit && ((mode == TASF_MODE_BYP2STR) || (mode == TASF_MODE_STR2FIFO))) begin
			triggered_reg <= 1'b1; // R10 R11
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Storage: one packed X,Y,Z entry per slot

	generate
		for (genvar i = 0; i < `TASF_DEPTH; i++) begin : g_slot
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					mem_reg[i] <= 48'h000000000000;
				end else if (slot_wr && (slot_idx == 5'(i))) begin
					mem_reg[i] <= {sample_x_i, sample_y_i, sample_z_i}; // R01
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Pointers and fill level; bypass holds them at zero, which is the restart

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || (eff == TASF_EFF_BYPASS)) begin
			wr_ptr_reg <= 5'h00; // R05 R07
		end else if (push) begin
			wr_ptr_reg <= wr_ptr_reg + 5'h01; // R06
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || (eff == TASF_EFF_BYPASS)) begin
			rd_ptr_reg <= 5'h00;
		end else if (pop || drop) begin
			rd_ptr_reg <= rd_ptr_reg + 5'h01; // R08 R14
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || (eff == TASF_EFF_BYPASS)) begin
			count_reg <= 6'h00; // R05
		end else if (push && !pop && !buf_full) begin
			count_reg <= count_reg + 6'h01; // R06
		end else if (pop && !push) begin
			count_reg <= count_reg - 6'h01; // R16 R17
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path; bypass reads slot zero, which is the live sample

	assign src_byte = {wtm_hit, buf_full, buf_empty, count_reg[4:0]}; // R03

	always_comb begin
		unique case (reg_addr_i)
			`TASF_ADDR_X_LOW:    rd_mux = head[39:32]; // R13
			`TASF_ADDR_X_HIGH:   rd_mux = head[47:40];
			`TASF_ADDR_Y_LOW:    rd_mux = head[23:16];
			`TASF_ADDR_Y_HIGH:   rd_mux = head[31:24];
			`TASF_ADDR_Z_LOW:    rd_mux = head[7:0];
			`TASF_ADDR_Z_HIGH:   rd_mux = head[15:8];
			`TASF_ADDR_CTRL:     rd_mux = buffer_control_reg;
			`TASF_ADDR_SRC:      rd_mux = src_byte;
			`TASF_ADDR_ROUTE:    rd_mux = interrupt_routing_control_reg;
			`TASF_ADDR_TRIG_CFG: rd_mux = trigger_event_config_reg;
			default:             rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd_i) begin
			rdata_reg <= rd_mux; // R14
		end
	end

	// Burst address stays inside the six output bytes so X,Y,Z repeat per sample
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			next_addr_reg <= `TASF_ADDR_X_LOW;
		end else if (reg_rd_i) begin
			next_addr_reg <= (reg_addr_i == `TASF_ADDR_Z_HIGH) ? `TASF_ADDR_X_LOW
				: reg_addr_i + 7'h01; // R15
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Second interrupt pin: level, one cycle behind the fill level

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (interrupt_routing_control_reg[`TASF_ROUTE_WTM_BIT] && wtm_hit) // R06 R09 R12
				|| (interrupt_routing_control_reg[`TASF_ROUTE_FULL_BIT] && buf_full) // R03
				|| (interrupt_routing_control_reg[`TASF_ROUTE_EMPTY_BIT] && buf_empty);
		end
	end

	assign reg_rdata_o      = rdata_reg;
	assign reg_next_addr_o  = next_addr_reg;
	assign second_irq_pin_o = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_ctrl_store;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		ctrl_wr |=> (buffer_control_reg == $past(reg_wdata_i));
	endproperty
	a_ctrl_store: assert property (p_ctrl_store) else $error("control write not stored"); // R02

	property p_src_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_rd_i && (reg_addr_i == `TASF_ADDR_SRC)) |=>
			(reg_rdata_o == {$past(wtm_hit), $past(buf_full), $past(buf_empty), $past(count_reg[4:0])});
	endproperty
	a_src_read: assert property (p_src_read) else $error("source register read wrong"); // R03

	property p_bypass_empty;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		((eff == TASF_EFF_BYPASS) && !ctrl_wr) |=> (count_reg == 6'h00) && (rd_ptr_reg == 5'h00);
	endproperty
	a_bypass_empty: assert property (p_bypass_empty) else $error("bypass holds samples"); // R05

	property p_wtm_irq;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(interrupt_routing_control_reg[`TASF_ROUTE_WTM_BIT] && (count_reg >= {1'b0, fill_threshold}))
			|=> second_irq_pin_o;
	endproperty
	a_wtm_irq: assert property (p_wtm_irq) else $error("threshold interrupt missing"); // R06

	property p_fifo_stop;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		((eff == TASF_EFF_FIFO) && buf_full && sample_valid_i && !pop && !ctrl_wr)
			|=> (count_reg == `TASF_FULL_COUNT) && $stable(wr_ptr_reg) && $stable(rd_ptr_reg);
	endproperty
	a_fifo_stop: assert property (p_fifo_stop) else $error("full fifo accepted sample"); // R07

	property p_stream_drop;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		((eff == TASF_EFF_STREAM) && buf_full && sample_valid_i && !pop && !ctrl_wr)
			|=> (count_reg == `TASF_FULL_COUNT) && (rd_ptr_reg == 5'($past(rd_ptr_reg) + 5'h01));
	endproperty
	a_stream_drop: assert property (p_stream_drop) else $error("stream did not drop oldest"); // R08

	sequence s_b2s_trigger;
		(mode == TASF_MODE_BYP2STR) && !triggered_reg && trig_hit && !ctrl_wr;
	endsequence
	property p_b2s_switch;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_b2s_trigger |=> triggered_reg ##0 ((eff == TASF_EFF_STREAM) || $changed(buffer_control_reg));
	endproperty
	a_b2s_switch: assert property (p_b2s_switch) else $error("bypass-to-stream did not switch"); // R10

	sequence s_s2f_trigger;
		(mode == TASF_MODE_STR2FIFO) && !triggered_reg && trig_hit && !ctrl_wr;
	endsequence
	property p_s2f_switch;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_s2f_trigger |=> triggered_reg ##0 ((eff == TASF_EFF_FIFO) || $changed(buffer_control_reg));
	endproperty
	a_s2f_switch: assert property (p_s2f_switch) else $error("stream-to-fifo did not switch"); // R11

	property p_oldest_read;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_rd_i && (reg_addr_i == `TASF_ADDR_X_LOW)) |=> (reg_rdata_o == $past(head[39:32]));
	endproperty
	a_oldest_read: assert property (p_oldest_read) else $error("read did not show oldest sample"); // R14

	property p_wrap;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_rd_i && (reg_addr_i == `TASF_ADDR_Z_HIGH)) |=> (reg_next_addr_o == `TASF_ADDR_X_LOW);
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst address did not wrap"); // R15

	property p_last_consumed;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(pop && (count_reg == 6'h01) && !push && !ctrl_wr) |=> buf_empty;
	endproperty
	a_last_consumed: assert property (p_last_consumed) else $error("empty not set"); // R16

	property p_full_clear;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(buf_full && pop && !sample_valid_i && !ctrl_wr) |=> !buf_full && (count_reg == 6'h1F);
	endproperty
	a_full_clear: assert property (p_full_clear) else $error("full not cleared"); // R17

	property p_fifo_count;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		((eff == TASF_EFF_FIFO) && sample_valid_i && !buf_full && !pop && !ctrl_wr)
			|=> (count_reg == 6'($past(count_reg) + 6'h01));
	endproperty
	a_fifo_count: assert property (p_fifo_count) else $error("fifo did not store sample"); // R06

	property p_bypass_slot;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		((eff == TASF_EFF_BYPASS) && sample_valid_i)
			|=> (mem_reg[0][47:32] == $past(sample_x_i))
				&& (mem_reg[0][31:16] == $past(sample_y_i))
				&& (mem_reg[0][15:0] == $past(sample_z_i));
	endproperty
	a_bypass_slot: assert property (p_bypass_slot) else $error("bypass sample not in slot zero"); // R05

	property p_irq_quiet;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(interrupt_routing_control_reg[`TASF_ROUTE_WTM_BIT:`TASF_ROUTE_EMPTY_BIT] == 3'h0)
			|=> !second_irq_pin_o;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("pin two raised with no event routed"); // R03

endmodule

`default_nettype wire

//--- bench/tasf_host_model.sv
// Host side of the buffer's register strobe interface: byte writes and byte reads.
// Assumes the buffer takes strobes on the rising edge of sys_clk_i and answers a read one
// cycle later.
`timescale 1ns/1ps
`default_nettype none

module tasf_host_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output var  logic [6:0] reg_addr_o,
	output var  logic       reg_wr_o,
	output var  logic [7:0] reg_wdata_o,
	output var  logic       reg_rd_o
);

	initial begin
		reg_addr_o  = 7'h7F;
		reg_wr_o    = 1'b0;
		reg_wdata_o = 8'hFF;
		reg_rd_o    = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Released lines show the inverse, so a stale value is never taken for a live one
	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		@(posedge sys_clk_i);
		#1;
		reg_addr_o  = addr;
		reg_wdata_o = data;
		reg_wr_o    = 1'b1;
		@(posedge sys_clk_i);
		#1;
		reg_wr_o    = 1'b0;
		reg_addr_o  = ~addr;
		reg_wdata_o = ~data;
	endtask

	task automatic rd(input logic [6:0] addr, output logic [7:0] data);
		@(posedge sys_clk_i);
		#1;
		reg_addr_o = addr;
		reg_rd_o   = 1'b1;
		@(posedge sys_clk_i);
		#1;
		reg_rd_o   = 1'b0;
		reg_addr_o = ~addr;
		data       = reg_rdata_i;
	endtask

	// Mode changes pass through bypass, which also restarts a halted fifo
	task automatic set_mode(input logic [7:0] ctrl);
		wr(7'h2E, 8'h00);
		wr(7'h2E, ctrl);
	endtask

endmodule

`default_nettype wire

//--- bench/tb_tasf_buffer.sv
// Self-checking bench for the three-axis sample buffer: register calls with expected values.
// Assumes tasf_pkg is compiled first and the host model drives the register strobes.
`timescale 1ns/1ps
`default_nettype none

module tb_tasf_buffer;
	import tasf_pkg::*;

	logic        sys_clk_i      = 1'b0;
	logic        rst_n_i        = 1'b0;
	logic        sample_valid_i = 1'b0;
	logic [15:0] sample_x_i     = 16'h0000;
	logic [15:0] sample_y_i     = 16'h0000;
	logic [15:0] sample_z_i     = 16'h0000;
	logic [5:0]  int1_events_i  = 6'h00;
	logic [6:0]  reg_addr_i;
	logic        reg_wr_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_rd_i;
	logic [7:0]  reg_rdata_o;
	logic [6:0]  reg_next_addr_o;
	logic        second_irq_pin_o;
	logic [7:0]  rd_data;
	int          failures       = 0;
	int          num_checks     = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;

	tasf_buffer i_tasf_buffer (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sample_valid_i(sample_valid_i),
		.sample_x_i(sample_x_i), .sample_y_i(sample_y_i), .sample_z_i(sample_z_i),
		.int1_events_i(int1_events_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.reg_next_addr_o(reg_next_addr_o), .second_irq_pin_o(second_irq_pin_o)
	);

	tasf_host_model i_tasf_host_model (
		.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
		.reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i)
	);

	////////////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic rd_chk(input logic [6:0] addr, input logic [7:0] exp);
		i_tasf_host_model.rd(addr, rd_data);
		check(rd_data, exp);
	endtask

	task automatic pin_chk(input logic exp);
		idle(3);
		check({7'h00, second_irq_pin_o}, {7'h00, exp});
	endtask

	// Sample i of a run carries 1000h, 2000h and 3000h plus base plus i on the three axes
	task automatic push(input int n, input int base);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk_i);
			#1;
			sample_valid_i = 1'b1;
			sample_x_i     = 16'(16'h1000 + base + i);
			sample_y_i     = 16'(16'h2000 + base + i);
			sample_z_i     = 16'(16'h3000 + base + i);
		end
		@(posedge sys_clk_i);
		#1;
		sample_valid_i = 1'b0;
	endtask

	task automatic pulse(input logic [5:0] ev);
		@(posedge sys_clk_i);
		#1;
		int1_events_i = ev;
		idle(1);
		int1_events_i = 6'h00;
		idle(1);
	endtask

	// Burst over all six output bytes; the address runs on and wraps after the last
	task automatic chk_sample(input int idx);
		logic [15:0] v [3];
		v[0] = 16'(16'h1000 + idx);
		v[1] = 16'(16'h2000 + idx);
		v[2] = 16'(16'h3000 + idx);
		for (int b = 0; b < 6; b++) begin
			i_tasf_host_model.rd(7'(7'h28 + b), rd_data);
			check(rd_data, b[0] ? v[b / 2][15:8] : v[b / 2][7:0]);
			check({1'b0, reg_next_addr_o}, (b == 5) ? 8'h28 : 8'(8'h29 + b));
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		idle(5);
		rst_n_i = 1'b1;
		check({7'h00, second_irq_pin_o}, 8'h00);
		check({1'b0, reg_next_addr_o}, 8'h28);
		rd_chk(7'h2E, 8'h00);
		rd_chk(7'h22, 8'h00);
		rd_chk(7'h30, 8'h00);
		// A zero threshold counts as reached even with nothing stored
		rd_chk(7'h2F, 8'hA0);
		rd_chk(7'h31, 8'h00);
		i_tasf_host_model.wr(7'h2F, 8'hFF);
		rd_chk(7'h2F, 8'hA0);
		i_tasf_host_model.wr(7'h22, 8'h04);
		rd_chk(7'h22, 8'h04);
		i_tasf_host_model.wr(7'h30, 8'h01);
		rd_chk(7'h30, 8'h01);
		// Bypass holds one sample and stays empty
		push(3, 0);
		rd_chk(7'h2F, 8'hA0);
		chk_sample(2);
		// Fifo: threshold at four, stop when full, restart through bypass
		i_tasf_host_model.set_mode({TASF_MODE_FIFO, 5'h04});
		rd_chk(7'h2E, 8'h24);
		push(3, 0);
		pin_chk(1'b0);
		push(1, 3);
		pin_chk(1'b1);
		push(30, 4);
		rd_chk(7'h2F, 8'hC0);
		chk_sample(0);
		rd_chk(7'h2F, 8'h9F);
		i_tasf_host_model.set_mode({TASF_MODE_FIFO, 5'h04});
		rd_chk(7'h2F, 8'h20);
		i_tasf_host_model.wr(7'h22, 8'h01);
		pin_chk(1'b1);
		i_tasf_host_model.wr(7'h22, 8'h04);
		pin_chk(1'b0);
		// Stream drops the oldest when full
		i_tasf_host_model.set_mode({TASF_MODE_STREAM, 5'h1F});
		push(34, 16'h40);
		rd_chk(7'h2F, 8'hC0);
		pin_chk(1'b1);
		chk_sample(16'h42);
		// Bypass-to-stream: an unselected event must not trigger
		i_tasf_host_model.set_mode({TASF_MODE_BYP2STR, 5'h02});
		pulse(6'h02);
		push(2, 16'h80);
		rd_chk(7'h2F, 8'h20);
		pulse(6'h01);
		push(3, 16'h90);
		rd_chk(7'h2F, 8'h83);
		chk_sample(16'h90);
		chk_sample(16'h91);
		chk_sample(16'h92);
		rd_chk(7'h2F, 8'h20);
		// Stream-to-fifo: after the trigger a full buffer keeps its oldest sample
		i_tasf_host_model.set_mode({TASF_MODE_STR2FIFO, 5'h04});
		push(34, 16'hA0);
		pulse(6'h01);
		push(1, 16'hF0);
		rd_chk(7'h2F, 8'hC0);
		pin_chk(1'b1);
		chk_sample(16'hA2);
		// Unassigned mode codes keep only the latest sample, as bypass does
		i_tasf_host_model.set_mode(8'hA4);
		push(2, 16'h30);
		rd_chk(7'h2F, 8'h20);
		chk_sample(16'h31);
		final_report();
	end

endmodule

`default_nettype wire
